// ===== hw/watchdog_clear_instruction_logic.sv
// Notes on behaviour
// - Bit clear zeroes only the chosen bit of the byte; no flags change.
// - Single watchdog clear restarts the counter and zeroes timeout and power-down flags.
// - First pre-clear acts only when alternating with second; then clears counter, flags.
// - Repeated first pre-clear without a second between does nothing at all.
// - Second pre-clear acts only alternating with first; repeats leave everything untouched.
`timescale 1ns/100ps
`default_nettype none

module watchdog_clear_instruction_logic
    import clear_exec_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic instr_valid_i,
    input wire instr_op_t instr_op_i,
    input wire logic [ADDR_WIDTH-1:0] bit_addr_i,
    input wire logic [BIT_SEL_WIDTH-1:0] bit_sel_i,
    // Core memory port
    input wire logic mem_write_i,
    input wire logic [ADDR_WIDTH-1:0] mem_write_addr_i,
    input wire logic [DATA_WIDTH-1:0] mem_write_data_i,
    input wire logic mem_read_i,
    input wire logic [ADDR_WIDTH-1:0] mem_read_addr_i,
    // Flag sets from the watchdog and power-down logic
    input wire logic timeout_set_i,
    input wire logic power_down_set_i,
    output logic [DATA_WIDTH-1:0] mem_read_data_o,
    output logic busy_o,
    output logic watchdog_clear_o,
    output logic timeout_flag_o,
    output logic power_down_flag_o,
    output logic last_preclear_o
);

    data_mem_if mem_bus ();

    data_mem i_data_mem (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .port(mem_bus.store)
    );

    bit_clear_state_t state;
    bit_clear_state_t next_state;
    logic [ADDR_WIDTH-1:0] target_addr;
    logic [DATA_WIDTH-1:0] clear_mask;
    logic take_instr;
    logic clear_event;
    logic first_ok;
    logic second_ok;
    logic [DATA_WIDTH-1:0] held_read_data;
    logic take_bit_clear;
    logic take_first;
    logic take_second;
    wire logic [DATA_WIDTH-1:0] cleared_byte;

    // New instructions are refused while a bit clear is in flight
    assign take_instr = instr_valid_i && (state == ST_IDLE);
    assign first_ok = (last_preclear_o == LAST_WAS_SECOND);
    assign second_ok = (last_preclear_o == LAST_WAS_FIRST);

    // Strobes for accepted instructions that own extra logic
    assign take_bit_clear = take_instr && (instr_op_i == OP_MEMORY_BIT_CLEAR);
    assign take_first = take_instr && (instr_op_i == OP_WATCHDOG_PRECLEAR_FIRST);
    assign take_second = take_instr && (instr_op_i == OP_WATCHDOG_PRECLEAR_SECOND);

    // Effective clears only; refused pre-clears leave all alone
    always_comb begin
        clear_event = 1'b0;
        if (take_instr) begin
            case (instr_op_i)
                OP_WATCHDOG_CLEAR_SINGLE: clear_event = 1'b1;
                OP_WATCHDOG_PRECLEAR_FIRST: clear_event = first_ok;
                OP_WATCHDOG_PRECLEAR_SECOND: clear_event = second_ok;
                default: clear_event = 1'b0;
            endcase
        end
    end

    // Alternation record, touched by pre-clears only
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            last_preclear_o <= LAST_PRECLEAR_RESET;
        end else if (take_first) begin
            last_preclear_o <= LAST_WAS_FIRST;
        end else if (take_second) begin
            last_preclear_o <= LAST_WAS_SECOND;
        end
    end

    // Counter restart pulse to the watchdog
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            watchdog_clear_o <= 1'b0;
        end else begin
            watchdog_clear_o <= clear_event;
        end
    end

    // Status flags: a hardware set in the same cycle wins over a clear
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            timeout_flag_o <= TIMEOUT_FLAG_RESET;
        end else if (timeout_set_i) begin
            timeout_flag_o <= 1'b1;
        end else if (clear_event) begin
            timeout_flag_o <= 1'b0;
        end
    end

    // Power-down flag, same set-over-clear priority
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            power_down_flag_o <= POWER_DOWN_FLAG_RESET;
        end else if (power_down_set_i) begin
            power_down_flag_o <= 1'b1;
        end else if (clear_event) begin
            power_down_flag_o <= 1'b0;
        end
    end

    // Bit clear sequencing: fetch the byte, then write it back masked
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take_bit_clear) begin
                    next_state = ST_FETCH;
                end
            end
            ST_FETCH: begin
                // Byte arrives from the store this cycle
                next_state = ST_WRITE;
            end
            ST_WRITE: begin
                // Masked byte goes back this cycle
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Address and mask caught when a bit clear is taken
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            target_addr <= '0;
            clear_mask <= MEM_RESET_VALUE;
        end else if (take_bit_clear) begin
            target_addr <= bit_addr_i;
            clear_mask <= BIT_MASK_BASE << bit_sel_i;
        end
    end

    // Busy taken from the next state so it lines up with state
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (next_state != ST_IDLE);
        end
    end

    // Write-back byte: every bit kept except the selected one
    for (genvar b = 0; b < DATA_WIDTH; b++) begin : g_clear_bit
        assign cleared_byte[b] = held_read_data[b] && !clear_mask[b];
    end

    // Read port: a bit clear fetch replaces a core read
    always_comb begin
        mem_bus.read_en = mem_read_i;
        mem_bus.read_addr = mem_read_addr_i;
        if (take_bit_clear) begin
            mem_bus.read_en = 1'b1;
            mem_bus.read_addr = bit_addr_i;
        end else if (state == ST_WRITE) begin
            mem_bus.read_en = 1'b0;
        end
    end

    // Write port: bit clear write-back has priority over the core's write
    always_comb begin
        mem_bus.write_en = mem_write_i && (state == ST_IDLE);
        mem_bus.write_addr = mem_write_addr_i;
        mem_bus.write_data = mem_write_data_i;
        if (state == ST_WRITE) begin
            mem_bus.write_en = 1'b1;
            mem_bus.write_addr = target_addr;
            mem_bus.write_data = cleared_byte;
        end
    end

    // Byte captured for the masked write-back
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            held_read_data <= MEM_RESET_VALUE;
        end else if (state == ST_FETCH) begin
            held_read_data <= mem_bus.read_data;
        end
    end

    // Core read data, held in the top as a flop
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mem_read_data_o <= MEM_RESET_VALUE;
        end else if (state == ST_FETCH || state == ST_IDLE) begin
            mem_read_data_o <= mem_bus.read_data;
        end
    end

endmodule : watchdog_clear_instruction_logic

`default_nettype wire

// ===== hw/clear_exec_pkg.sv
package clear_exec_pkg;

    localparam int DATA_WIDTH = 8;
    localparam int ADDR_WIDTH = 8;
    localparam int BIT_SEL_WIDTH = 3;
    localparam int MEM_DEPTH = 256;

    localparam logic [DATA_WIDTH-1:0] MEM_RESET_VALUE = 8'h00;
    localparam logic [DATA_WIDTH-1:0] BIT_MASK_BASE = 8'h01;
    localparam logic TIMEOUT_FLAG_RESET = 1'b0;
    localparam logic POWER_DOWN_FLAG_RESET = 1'b0;

    // Record value after reset: first pre-clear is the one that may act first
    localparam logic LAST_WAS_FIRST = 1'b1;
    localparam logic LAST_WAS_SECOND = 1'b0;
    localparam logic LAST_PRECLEAR_RESET = LAST_WAS_SECOND;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_MEMORY_BIT_CLEAR,
        OP_WATCHDOG_CLEAR_SINGLE,
        OP_WATCHDOG_PRECLEAR_FIRST,
        OP_WATCHDOG_PRECLEAR_SECOND
    } instr_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_WRITE
    } bit_clear_state_t;

endpackage : clear_exec_pkg

// ===== hw/data_mem_if.sv
`timescale 1ns/100ps
`default_nettype none

interface data_mem_if;
    import clear_exec_pkg::*;

    logic write_en;
    logic [ADDR_WIDTH-1:0] write_addr;
    logic [DATA_WIDTH-1:0] write_data;
    logic read_en;
    logic [ADDR_WIDTH-1:0] read_addr;
    logic [DATA_WIDTH-1:0] read_data;

    modport user (
        output write_en, write_addr, write_data, read_en, read_addr,
        input read_data
    );
    modport store (
        input write_en, write_addr, write_data, read_en, read_addr,
        output read_data
    );
endinterface : data_mem_if

`default_nettype wire

// ===== hw/data_mem.sv
`timescale 1ns/100ps
`default_nettype none

module data_mem
    import clear_exec_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    data_mem_if.store port
);

    logic [DATA_WIDTH-1:0] cells [MEM_DEPTH];

    always_ff @(posedge clk_i) begin
        if (port.write_en) begin
            cells[port.write_addr] <= port.write_data;
        end
    end

    // Registered read port
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            port.read_data <= MEM_RESET_VALUE;
        end else if (port.read_en) begin
            port.read_data <= cells[port.read_addr];
        end
    end

endmodule : data_mem

`default_nettype wire

// ===== testbench/wcil_chk.sv
`timescale 1ns/100ps
`default_nettype none
module wcil_chk
    import clear_exec_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic instr_valid_i,
    input wire instr_op_t instr_op_i,
    input wire logic timeout_set_i,
    input wire logic power_down_set_i,
    input wire logic busy_o,
    input wire logic watchdog_clear_o,
    input wire logic timeout_flag_o,
    input wire logic power_down_flag_o,
    input wire logic last_preclear_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (reset_i);
logic tk;
logic qt;
assign tk = instr_valid_i && !busy_o;
assign qt = tk && !timeout_set_i && !power_down_set_i;
AST_BIT_BUSY: assert property (tk && instr_op_i == OP_MEMORY_BIT_CLEAR |=>
    busy_o [*2] ##1 !busy_o) else $error("bit clear busy span wrong");
AST_BIT_FLAGS: assert property (qt && instr_op_i == OP_MEMORY_BIT_CLEAR |=>
    !watchdog_clear_o && $stable(timeout_flag_o) && $stable(power_down_flag_o))
    else $error("bit clear touched watchdog state");
AST_SINGLE: assert property (qt && instr_op_i == OP_WATCHDOG_CLEAR_SINGLE |=>
    watchdog_clear_o && !timeout_flag_o && !power_down_flag_o)
    else $error("single clear failed");
AST_FIRST_OK: assert property (qt && instr_op_i == OP_WATCHDOG_PRECLEAR_FIRST
    && !last_preclear_o |=> watchdog_clear_o && !timeout_flag_o && !power_down_flag_o
    && last_preclear_o)
    else $error("first pre-clear failed");
AST_FIRST_REP: assert property (qt && instr_op_i == OP_WATCHDOG_PRECLEAR_FIRST
    && last_preclear_o |=> !watchdog_clear_o && $stable(power_down_flag_o)
    && $stable(timeout_flag_o))
    else $error("repeated first pre-clear acted");
AST_SECOND: assert property (tk && instr_op_i == OP_WATCHDOG_PRECLEAR_SECOND |=>
    watchdog_clear_o == $past(last_preclear_o) && !last_preclear_o)
    else $error("second pre-clear wrong");
AST_RECORD: assert property (!(tk && (instr_op_i == OP_WATCHDOG_PRECLEAR_FIRST ||
    instr_op_i == OP_WATCHDOG_PRECLEAR_SECOND)) |=> $stable(last_preclear_o))
    else $error("record changed without pre-clear");
AST_BUSY_REFUSE: assert property (instr_valid_i && busy_o |=> !watchdog_clear_o)
    else $error("instruction taken while busy");
AST_TO_SET_WINS: assert property (timeout_set_i |=> timeout_flag_o)
    else $error("timeout set lost");
AST_PD_SET_WINS: assert property (power_down_set_i |=> power_down_flag_o)
    else $error("power-down set lost");
endmodule : wcil_chk
bind watchdog_clear_instruction_logic wcil_chk i_wcil_chk (.clk_i, .reset_i,
    .instr_valid_i, .instr_op_i, .timeout_set_i, .power_down_set_i, .busy_o,
    .watchdog_clear_o, .timeout_flag_o, .power_down_flag_o, .last_preclear_o);
`default_nettype wire

// ===== testbench/watchdog_clear_instruction_logic_bench.sv
`timescale 1ns/100ps
`default_nettype none
module watchdog_clear_instruction_logic_bench
    import clear_exec_pkg::*;
;
logic clk_i = 0, reset_i = 1, instr_valid_i = 0, mem_write_i = 0, mem_read_i = 0;
logic timeout_set_i = 0, power_down_set_i = 0;
instr_op_t instr_op_i = OP_NONE;
logic [7:0] bit_addr_i = 0, mem_write_addr_i = 0, mem_write_data_i = 0;
logic [7:0] mem_read_addr_i = 0, mem_read_data_o;
logic [2:0] bit_sel_i = 0;
logic busy_o, watchdog_clear_o, timeout_flag_o, power_down_flag_o, last_preclear_o;
int err_total = 0, comparisons = 0;
watchdog_clear_instruction_logic i_watchdog_clear_instruction_logic (.clk_i, .reset_i,
    .instr_valid_i, .instr_op_i, .bit_addr_i, .bit_sel_i, .mem_write_i,
    .mem_write_addr_i, .mem_write_data_i, .mem_read_i, .mem_read_addr_i,
    .timeout_set_i, .power_down_set_i, .mem_read_data_o, .busy_o,
    .watchdog_clear_o, .timeout_flag_o, .power_down_flag_o, .last_preclear_o);
always #10 clk_i = ~clk_i;
task automatic step;
    @(posedge clk_i);
    #2;
endtask : step
task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
        err_total++;
        $display("Error %s expected %h seen %h", n, e, s);
    end
endtask : chk
// Status nibble: timeout, power-down, clear pulse, record
task automatic st(input logic [3:0] e);
    chk("status", {4'h0, timeout_flag_o, power_down_flag_o, watchdog_clear_o,
        last_preclear_o}, {4'h0, e});
endtask : st
task automatic op(input instr_op_t o);
    step();
    instr_valid_i = 1;
    instr_op_i = o;
    step();
    instr_valid_i = 0;
    instr_op_i = OP_NONE;
endtask : op
task automatic setf;
    timeout_set_i = 1;
    power_down_set_i = 1;
    step();
    timeout_set_i = 0;
    power_down_set_i = 0;
endtask : setf
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step();
    mem_write_i = 1;
    mem_write_addr_i = a;
    mem_write_data_i = d;
    step();
    mem_write_i = 0;
endtask : wr
task automatic rd(input logic [7:0] a, input logic [7:0] e);
    mem_read_i = 1;
    mem_read_addr_i = a;
    step();
    mem_read_i = 0;
    step();
    chk("mem", mem_read_data_o, e);
endtask : rd
task automatic bclr(input logic [7:0] a, input logic [2:0] b);
    bit_addr_i = a;
    bit_sel_i = b;
    op(OP_MEMORY_BIT_CLEAR);
    chk("busy", {7'h0, busy_o}, 8'h01);
    step();
    step();
endtask : bclr
task automatic t_single;
    setf();
    st(4'hc);
    op(OP_WATCHDOG_CLEAR_SINGLE);
    st(4'h2);
endtask : t_single
task automatic t_pair;
    setf();
    op(OP_WATCHDOG_PRECLEAR_FIRST);
    st(4'h3);
    setf();
    op(OP_WATCHDOG_PRECLEAR_FIRST);
    st(4'hd);
    op(OP_WATCHDOG_PRECLEAR_SECOND);
    st(4'h2);
    setf();
    op(OP_WATCHDOG_PRECLEAR_SECOND);
    st(4'hc);
    op(OP_WATCHDOG_PRECLEAR_FIRST);
    op(OP_WATCHDOG_CLEAR_SINGLE);
    st(4'h3);
    bclr(8'h10, 3'h1);
    op(OP_WATCHDOG_PRECLEAR_FIRST);
    st(4'h1);
    op(OP_WATCHDOG_PRECLEAR_SECOND);
    st(4'h2);
endtask : t_pair
task automatic t_bit;
    setf();
    wr(8'h3c, 8'hff);
    wr(8'h3d, 8'haa);
    bclr(8'h3c, 3'h7);
    st(4'hc);
    rd(8'h3c, 8'h7f);
    bclr(8'h3c, 3'h0);
    rd(8'h3c, 8'h7e);
    rd(8'h3d, 8'haa);
endtask : t_bit
task automatic t_clash;
    step();
    timeout_set_i = 1;
    instr_valid_i = 1;
    instr_op_i = OP_WATCHDOG_CLEAR_SINGLE;
    step();
    timeout_set_i = 0;
    instr_valid_i = 0;
    instr_op_i = OP_NONE;
    st(4'ha);
endtask : t_clash
task automatic t_refuse;
    wr(8'h40, 8'hf0);
    wr(8'h41, 8'h33);
    bit_addr_i = 8'h40;
    bit_sel_i = 3'h4;
    instr_valid_i = 1;
    instr_op_i = OP_MEMORY_BIT_CLEAR;
    step();
    // Valid stays up: single clear and core write arrive while busy and are both dropped
    instr_op_i = OP_WATCHDOG_CLEAR_SINGLE;
    mem_write_i = 1;
    mem_write_addr_i = 8'h41;
    mem_write_data_i = 8'h55;
    chk("busy", {7'h0, busy_o}, 8'h01);
    step();
    instr_valid_i = 0;
    instr_op_i = OP_NONE;
    mem_write_i = 0;
    st(4'h8);
    step();
    rd(8'h40, 8'he0);
    rd(8'h41, 8'h33);
endtask : t_refuse
task automatic complete_run;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
        $display("NO MISMATCHES");
    end else begin
        $display("MISMATCHES SEEN");
    end
    $finish;
endtask : complete_run
initial begin
    #20us;
    err_total++;
    complete_run();
end
initial begin
    repeat (10) @(posedge clk_i);
    #2 reset_i = 0;
    st(4'h0);
    t_single();
    t_pair();
    t_bit();
    t_clash();
    t_refuse();
    complete_run();
end
endmodule : watchdog_clear_instruction_logic_bench
`default_nettype wire
